// [asrc_host.sv]
// Host controller driving an asynchronous static memory
module asrc_host (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire asrc_pkg::asrc_req_t req,
   input wire logic req_valid,
   output logic req_ready,
   output logic [asrc_pkg::DATA_W-1:0] rd_data,
   output logic rd_valid,
   output asrc_pkg::asrc_pins_t pins,
   input wire logic [asrc_pkg::DATA_W-1:0] io_bus_in,
   output logic [asrc_pkg::DATA_W-1:0] io_bus_out,
   output logic io_bus_oe
);
   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   asrc_pkg::asrc_state_t state_q, state_d;
   logic [asrc_pkg::CNT_W-1:0] cnt_q, cnt_d;
   asrc_pkg::asrc_pins_t pins_q, pins_d;
   logic [asrc_pkg::DATA_W-1:0] wdat_q, wdat_d, rdat_q, rdat_d;
   logic oe_q, oe_d, rdv_q, rdv_d, rdy_q, rdy_d;
   wire take = rdy_q & req_valid;
   wire cnt_done = (cnt_q == asrc_pkg::CNT_ONE);
   wire [asrc_pkg::CNT_W-1:0] cnt_dec = cnt_q - asrc_pkg::CNT_ONE;

   // ------------------------------------------------------------
   // Sequencer
   // ------------------------------------------------------------
   always_comb begin
      state_d = state_q;
      cnt_d = cnt_q;
      pins_d = pins_q;
      wdat_d = wdat_q;
      rdat_d = rdat_q;
      oe_d = oe_q;
      rdv_d = 1'b0;
      rdy_d = rdy_q;
      case (state_q)
         asrc_pkg::ST_IDLE: begin
            if (take) begin
               rdy_d = 1'b0;
               pins_d.addr = req.addr;
               pins_d.cs_n = 1'b0;
               if (req.write) begin
                  // host drives only with output enable high
                  pins_d.oe_n = 1'b1;
                  wdat_d = req.wdata;
                  state_d = asrc_pkg::ST_WSETUP;
               end else begin
                  pins_d.store_strobe_n = 1'b1;
                  pins_d.oe_n = 1'b0;
                  cnt_d = 4'(asrc_pkg::RD_CYC);
                  state_d = asrc_pkg::ST_READ;
               end
            end
         end
         asrc_pkg::ST_READ: begin
            cnt_d = cnt_dec;
            if (cnt_done) begin
               rdat_d = io_bus_in;
               rdv_d = 1'b1;
               pins_d.cs_n = 1'b1;
               pins_d.oe_n = 1'b1;
               cnt_d = 4'(asrc_pkg::OZ_CYC);
               state_d = asrc_pkg::ST_TURN;
            end
         end
         asrc_pkg::ST_WSETUP: begin
            // write starts on strobe within select
            pins_d.store_strobe_n = 1'b0;
            // drive data a cycle after strobe
            cnt_d = 4'(asrc_pkg::WP_CYC);
            state_d = asrc_pkg::ST_WPULSE;
         end
         asrc_pkg::ST_WPULSE: begin
            oe_d = 1'b1;
            cnt_d = cnt_dec;
            if (cnt_done) begin
               pins_d.store_strobe_n = 1'b1;
               cnt_d = asrc_pkg::CNT_ONE;
               state_d = asrc_pkg::ST_TURN;
            end
         end
         asrc_pkg::ST_TURN: begin
            if (pins_q.store_strobe_n && pins_q.cs_n == 1'b0) begin
               pins_d.cs_n = 1'b1;
            end
            oe_d = 1'b0;
            cnt_d = cnt_dec;
            if (cnt_done) begin
               rdy_d = 1'b1;
               state_d = asrc_pkg::ST_IDLE;
            end
         end
         default: begin
            state_d = asrc_pkg::ST_IDLE;
         end
      endcase
   end

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         state_q <= asrc_pkg::ST_IDLE;
         cnt_q <= asrc_pkg::CNT_ZERO;
         pins_q <= '{cs_n: 1'b1, oe_n: 1'b1, store_strobe_n: 1'b1,
                     addr: '0};
         wdat_q <= 8'h00;
         rdat_q <= 8'h00;
         oe_q <= 1'b0;
         rdv_q <= 1'b0;
         rdy_q <= 1'b0;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         pins_q <= pins_d;
         wdat_q <= wdat_d;
         rdat_q <= rdat_d;
         oe_q <= oe_d;
         rdv_q <= rdv_d;
         rdy_q <= (state_q == asrc_pkg::ST_IDLE && !take) ? 1'b1 : rdy_d;
      end
   end

   assign pins = pins_q;
   assign req_ready = rdy_q;
   assign rd_data = rdat_q;
   assign rd_valid = rdv_q;
   assign io_bus_out = wdat_q;
   assign io_bus_oe = oe_q;
endmodule : asrc_host

// [asrc_host_test.sv]
// Self-checking bench for the static memory host
module asrc_host_test;
   timeunit 1ns;
   timeprecision 100ps;
   logic core_clk = 1'b0;
   logic reset_n = 1'b0;
   asrc_pkg::asrc_req_t req = '0;
   logic req_valid = 1'b0;
   logic req_ready, rd_valid, io_bus_oe;
   logic [7:0] rd_data, io_bus_in, io_bus_out;
   asrc_pkg::asrc_pins_t pins;
   int num_errors = 0;
   int cmp_count = 0;
   always #2 core_clk = ~core_clk;
   asrc_host uut (.core_clk, .reset_n, .req, .req_valid, .req_ready,
      .rd_data, .rd_valid, .pins, .io_bus_in, .io_bus_out, .io_bus_oe);
   asrc_sram_model mem_m (.pins, .io_bus_oe, .io_bus_out, .io_bus_in);
   task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
      cmp_count++;
      if (g !== e) begin
         num_errors++;
         $display("Error %s exp %h got %h", nm, e, g);
      end
   endtask : chk
   task automatic send(logic w, logic [16:0] a, logic [7:0] d);
      @(posedge core_clk);
      req <= '{w, a, d};
      req_valid <= 1'b1;
      do @(posedge core_clk); while (req_ready !== 1'b1);
      req_valid <= 1'b0;
   endtask : send
   task automatic rd(logic [16:0] a, logic [7:0] e);
      send(1'b0, a, 8'h00);
      repeat (3) @(posedge core_clk);
      #1;
      chk("rd_valid", 8'h01, {7'h00, rd_valid});
      chk("rd_data", e, rd_data);
   endtask : rd
   task automatic test_fill;
      send(1'b1, 17'h00000, 8'h5a);
      send(1'b1, 17'h1ffff, 8'ha5);
      rd(17'h00000, 8'h5a);
      rd(17'h1ffff, 8'ha5);
      $display("test_fill done");
   endtask : test_fill
   task automatic test_over;
      send(1'b1, 17'h0a5a5, 8'hff);
      send(1'b1, 17'h0a5a5, 8'h00);
      rd(17'h0a5a5, 8'h00);
      rd(17'h00000, 8'h5a);
      $display("test_over done");
   endtask : test_over
   task automatic report_and_stop;
      $display("errors %0d compares %0d", num_errors, cmp_count);
      if (num_errors == 0 && cmp_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : report_and_stop
   initial begin
      repeat (12) @(posedge core_clk);
      reset_n <= 1'b1;
      test_fill();
      test_over();
      report_and_stop();
   end
   initial begin
      #20000;
      num_errors++;
      report_and_stop();
   end
endmodule : asrc_host_test

// [asrc_monitor.sv]
// Checker for the static memory host pins
module asrc_monitor (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire asrc_pkg::asrc_pins_t pins,
   input wire logic io_bus_oe,
   input wire logic rd_valid,
   input wire logic req_valid,
   input wire logic req_ready
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!reset_n);
   rd_strb_a:
      assert property (!pins.oe_n |-> pins.store_strobe_n) else $error("w");
   rd_time_a:
      assert property (rd_valid |-> $past(!pins.oe_n, 3)) else $error("t");
   strb_wide_a:
      assert property ($fell(pins.store_strobe_n) |=> !pins.store_strobe_n)
      else $error("p");
   addr_hold_a:
      assert property (!pins.store_strobe_n |-> $stable(pins.addr))
      else $error("a");
   data_set_a:
      assert property ($rose(pins.store_strobe_n) |-> io_bus_oe
      && $past(io_bus_oe)) else $error("d");
   wr_cyc_a:
      assert property ($fell(pins.cs_n) |=> !pins.cs_n) else $error("c");
   no_clash_a:
      assert property (io_bus_oe |-> pins.oe_n) else $error("o");
   wr_end_a:
      assert property ($rose(pins.cs_n) |-> $past(pins.store_strobe_n))
      else $error("e");
   cover property (rd_valid);
   cover property ($fell(pins.store_strobe_n));
   cover property (req_valid && !req_ready);
endmodule : asrc_monitor
bind asrc_host asrc_monitor u_mon (.*);

// [asrc_pkg.sv]
// Package for the asynchronous static memory host controller
package asrc_pkg;
   // ------------------------------------------------------------
   // Widths and clock period
   // ------------------------------------------------------------
   localparam int ADDR_W = 17;
   localparam int DATA_W = 8;
   localparam int CLK_PS = 4000;
   // ------------------------------------------------------------
   // Timing in picoseconds, fastest grade
   // ------------------------------------------------------------
   localparam int T_RC_PS = 8000;
   localparam int T_AA_PS = 8000;
   localparam int T_WP_PS = 8000;
   localparam int T_DW_PS = 4000;
   localparam int T_WC_PS = 8000;
   localparam int T_OZ_PS = 4000;
   // ------------------------------------------------------------
   // Cycle counts, least times rounded up, one cycle more for RD_CYC and OZ_CYC
   // ------------------------------------------------------------
   localparam int RD_CYC = (T_AA_PS + CLK_PS - 1) / CLK_PS + 1;
   localparam int WP_CYC = (T_WP_PS + CLK_PS - 1) / CLK_PS;
   localparam int DW_CYC = (T_DW_PS + CLK_PS - 1) / CLK_PS;
   localparam int WC_CYC = (T_WC_PS + CLK_PS - 1) / CLK_PS;
   localparam int OZ_CYC = (T_OZ_PS + CLK_PS - 1) / CLK_PS + 1;
   localparam int RC_CYC = (T_RC_PS + CLK_PS - 1) / CLK_PS;
   localparam int CNT_W = 4;
   localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
   localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
   // ------------------------------------------------------------
   // Types
   // ------------------------------------------------------------
   typedef struct packed {
      logic write;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } asrc_req_t;
   typedef struct packed {
      logic cs_n;
      logic oe_n;
      logic store_strobe_n;
      logic [ADDR_W-1:0] addr;
   } asrc_pins_t;
   typedef enum logic [2:0] {
      ST_IDLE, ST_READ, ST_WSETUP, ST_WPULSE, ST_TURN
   } asrc_state_t;
endpackage : asrc_pkg

// [asrc_sram_model.sv]
// Behavioural model of the static memory
module asrc_sram_model (
   input wire asrc_pkg::asrc_pins_t pins,
   input wire logic io_bus_oe,
   input wire logic [asrc_pkg::DATA_W-1:0] io_bus_out,
   output logic [asrc_pkg::DATA_W-1:0] io_bus_in
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [7:0] mem [0:131071];
   logic drv_q = 1'b0;
   logic flt_q = 1'b0;
   wire rd_d = !pins.cs_n && !pins.oe_n && pins.store_strobe_n;
   always #2 flt_q = ~flt_q;
   always @(rd_d) drv_q <= #(rd_d ? 3 : 2) rd_d;
   assign io_bus_in = io_bus_oe ? io_bus_out
      : drv_q ? mem[pins.addr] : {8{flt_q}};
   always @(posedge pins.store_strobe_n)
      if (!pins.cs_n) mem[pins.addr] = io_bus_out;
endmodule : asrc_sram_model
